// ### inc/bot_regs.vh
`ifndef BOT_REGS_VH
`define BOT_REGS_VH

// Register byte offsets
`define BOT_PORT_OPT_OFS 8'h74
`define BOT_RETRY_LIM_OFS 8'h78
`define BOT_MASTER_TMO_OFS 8'h80
`define BOT_SLOT_CAP_OFS 8'hB0
`define BOT_POWER_CAP_OFS 8'hDC
`define BOT_EVENT_STAT_OFS 8'hF0

// Port option field positions
`define BOT_OPT_SEC_WR_ALIAS 4
`define BOT_OPT_PRI_WI_DISC 7
`define BOT_OPT_SEC_WI_DISC 8
`define BOT_OPT_LOCK_LONG 9
`define BOT_OPT_SEC_HOLD 10
`define BOT_OPT_PRI_HOLD 11

// Reset values and writable masks
`define BOT_PORT_OPT_RST 16'h0C00
`define BOT_PORT_OPT_WMASK 16'h0F90
`define BOT_RETRY_LIM_RST 32'h01000000
`define BOT_PRI_TMO_RST 16'h8000
`define BOT_SEC_TMO_RST 16'h8000
`define BOT_SLOT_INFO_RST 8'h00
`define BOT_SLOT_INFO_WMASK 8'h3F
`define BOT_CHASSIS_RST 8'h00

// Capability list constants
`define BOT_SLOT_CAP_CODE 8'h04
`define BOT_SLOT_NEXT_END 8'h00
`define BOT_POWER_CAP_CODE 8'h01
`define BOT_POWER_NEXT_LINK 8'h0B
`define BOT_POWER_REV 3'h1

// Event status bit positions
`define BOT_EV_RETRY 0
`define BOT_EV_PRI_TMO 1
`define BOT_EV_SEC_TMO 2

// Bus command encodings
`define BOT_CMD_WRITE_INVALIDATE 4'hF
`define BOT_CMD_PLAIN_WRITE 4'h7

// Bus responses
`define BOT_RESP_OKAY 2'h0
`define BOT_RESP_SLVERR 2'h2

`endif

// ### verilog/bot_limit_counter.v
`default_nettype none

// Counts steps and pulses hit_o once the count reaches the limit, then restarts
module bot_limit_counter #(
	parameter W = 16
) (
	input wire clk_i,
	input wire rst_i,
	input wire ce_i,
	input wire clear_i,
	input wire step_i,
	input wire [W-1:0] limit_i,
	output reg hit_o
);
	reg [W-1:0] count;
	wire [W-1:0] next_count;

	assign next_count = count + {{(W-1){1'b0}}, 1'b1};

	// A limit of zero hits on every step, since the compare is a reach test
	always @(posedge clk_i) begin
		if (rst_i) begin
			count <= {W{1'b0}};
			hit_o <= 1'b0;
		end else if (ce_i) begin
			hit_o <= 1'b0;
			if (clear_i) begin
				count <= {W{1'b0}};
			end else if (step_i) begin
				if (next_count >= limit_i) begin
					hit_o <= 1'b1;
					count <= {W{1'b0}};
				end else begin
					count <= next_count;
				end
			end
		end
	end
endmodule // bot_limit_counter

`default_nettype wire

// ### verilog/bot_option_regs.v
// Overview of operation
// R1: Bit 4 aliases secondary invalidate-write retries to writes
// R2: Bit 7 clear: primary invalidate-write forwarded plain
// R3: Bit 8 clear: secondary invalidate-write forwarded plain
// R4: Control bit set: disconnect at cache line boundary
// R5: Bit 9 enables long lock request, resets 0
// R6: Bit 10 secondary request hold policy, resets 1
// R7: Bit 11 primary request hold policy, resets 1
// R8: Reserved bits read zero, reset zero
// R9: Retry limit word, read/write, default 01000000h
// R10: Primary master timeout bits 15:0, reset 8000h
// R11: Secondary master timeout bits 31:16, reset 8000h
// R12: Slot capability code at B0h reads 04h
// R13: Slot next pointer 00h per mode pins
// R14: Slot number, first flag, chassis: read/write, zero
// R15: Power capability code at DCh reads 01h
// R16: Power next pointer reads 0Bh
// R17: Count attempts and clocks, flag timeouts
//
// Register access over AXI4-Lite is this design's own decision.
`include "bot_regs.vh"
`default_nettype none

module bot_option_regs #(
	parameter [7:0] SLOT_NEXT_ALT = 8'hDC
) (
	input wire clk_i,
	input wire rst_i,
	input wire ce_i,
	// AXI4-Lite register port
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// Mode strap pins
	input wire mode_select_pin_zero_i,
	input wire mode_select_pin_one_i,
	// Primary side commands
	input wire [3:0] prim_cmd_i,
	input wire prim_cmd_valid_i,
	input wire prim_line_end_i,
	output reg [3:0] prim_fwd_cmd_o,
	output reg prim_fwd_valid_o,
	output reg prim_wi_disconnect_o,
	// Secondary side commands
	input wire [3:0] sec_cmd_i,
	input wire sec_cmd_valid_i,
	input wire sec_line_end_i,
	output reg [3:0] sec_fwd_cmd_o,
	output reg sec_fwd_valid_o,
	output reg sec_wi_disconnect_o,
	// Secondary retry matching
	input wire [3:0] sec_retry_cmd_i,
	input wire [3:0] sec_queued_cmd_i,
	input wire sec_retry_valid_i,
	output reg sec_retry_match_o,
	// Master policies
	output reg lock_long_req_o,
	output reg prim_hold_req_o,
	output reg sec_hold_req_o,
	// Timeout counting
	input wire attempt_i,
	input wire delivered_i,
	input wire prim_wait_i,
	input wire sec_wait_i,
	output wire retry_timeout_o,
	output wire prim_timeout_o,
	output wire sec_timeout_o
);
	// Register state
	reg [15:0] port_opt;
	reg [31:0] retry_lim;
	reg [15:0] pri_tmo;
	reg [15:0] sec_tmo;
	reg [7:0] slot_info;
	reg [7:0] chassis;
	reg [2:0] ev_stat;

	// Write channel holding state
	reg aw_held;
	reg w_held;
	reg [7:0] aw_addr;
	reg [31:0] w_data;
	reg [3:0] w_strb;

	// Strap synchronisers
	reg mode0_meta;
	reg mode0_sync;
	reg mode1_meta;
	reg mode1_sync;

	wire do_aw;
	wire do_w;
	wire commit;
	wire do_ar;
	wire [31:0] bmask;
	wire wr_opt;
	wire wr_retry;
	wire wr_tmo;
	wire wr_slot;
	wire wr_stat;
	wire [2:0] ev_set;
	reg [7:0] slot_next;
	reg [31:0] next_rdata;
	reg [1:0] next_rresp;
	reg addr_ok;

	assign do_aw = s_axi_awvalid & s_axi_awready;
	assign do_w = s_axi_wvalid & s_axi_wready;
	assign commit = aw_held & w_held & ~s_axi_bvalid;
	assign do_ar = s_axi_arvalid & s_axi_arready;
	assign bmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
	assign wr_opt = commit & (aw_addr == `BOT_PORT_OPT_OFS);
	assign wr_retry = commit & (aw_addr == `BOT_RETRY_LIM_OFS);
	assign wr_tmo = commit & (aw_addr == `BOT_MASTER_TMO_OFS);
	assign wr_slot = commit & (aw_addr == `BOT_SLOT_CAP_OFS);
	assign wr_stat = commit & (aw_addr == `BOT_EVENT_STAT_OFS);
	assign ev_set = {sec_timeout_o, prim_timeout_o, retry_timeout_o};

	// Pins are asynchronous to the bus clock, so only the second stage is used
	always @(posedge clk_i) begin
		if (rst_i) begin
			mode0_meta <= 1'b0;
			mode0_sync <= 1'b0;
			mode1_meta <= 1'b0;
			mode1_sync <= 1'b0;
		end else if (ce_i) begin
			mode0_meta <= mode_select_pin_zero_i;
			mode0_sync <= mode0_meta;
			mode1_meta <= mode_select_pin_one_i;
			mode1_sync <= mode1_meta;
		end
	end

	// Slot list end depends on strap pins
	always @* begin
		if (mode0_sync | mode1_sync) begin
			slot_next = `BOT_SLOT_NEXT_END; // R13
		end else begin
			slot_next = SLOT_NEXT_ALT;
		end
	end

	// Read decode; unmapped offsets answer zero with an error response
	always @* begin
		next_rdata = 32'h00000000;
		addr_ok = 1'b1;
		case (s_axi_araddr)
			`BOT_PORT_OPT_OFS: begin
				next_rdata = {16'h0000, port_opt & `BOT_PORT_OPT_WMASK}; // R8
			end
			`BOT_RETRY_LIM_OFS: begin
				next_rdata = retry_lim; // R9
			end
			`BOT_MASTER_TMO_OFS: begin
				next_rdata = {sec_tmo, pri_tmo}; // R10 R11
			end
			`BOT_SLOT_CAP_OFS: begin
				next_rdata = {chassis, slot_info & `BOT_SLOT_INFO_WMASK, slot_next,
					`BOT_SLOT_CAP_CODE}; // R12 R14 R8
			end
			`BOT_POWER_CAP_OFS: begin
				next_rdata = {13'h0, `BOT_POWER_REV, `BOT_POWER_NEXT_LINK,
					`BOT_POWER_CAP_CODE}; // R15 R16
			end
			`BOT_EVENT_STAT_OFS: begin
				next_rdata = {29'h0, ev_stat};
			end
			default: begin
				addr_ok = 1'b0;
			end
		endcase
		next_rresp = addr_ok ? `BOT_RESP_OKAY : `BOT_RESP_SLVERR;
	end

	// Address and data are taken independently; commit waits for both
	always @(posedge clk_i) begin
		if (rst_i) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `BOT_RESP_OKAY;
		end else if (ce_i) begin
			if (commit) begin
				aw_held <= 1'b0;
				s_axi_awready <= 1'b1;
			end else if (do_aw) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (commit) begin
				w_held <= 1'b0;
				s_axi_wready <= 1'b1;
			end else if (do_w) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (commit) begin
				s_axi_bvalid <= 1'b1;
				if ((aw_addr == `BOT_PORT_OPT_OFS) || (aw_addr == `BOT_RETRY_LIM_OFS) ||
					(aw_addr == `BOT_MASTER_TMO_OFS) || (aw_addr == `BOT_SLOT_CAP_OFS) ||
					(aw_addr == `BOT_POWER_CAP_OFS) || (aw_addr == `BOT_EVENT_STAT_OFS)) begin
					s_axi_bresp <= `BOT_RESP_OKAY;
				end else begin
					s_axi_bresp <= `BOT_RESP_SLVERR;
				end
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Read answer is registered on the edge that takes the address
	always @(posedge clk_i) begin
		if (rst_i) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `BOT_RESP_OKAY;
		end else if (ce_i) begin
			if (do_ar) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= next_rdata;
				s_axi_rresp <= next_rresp;
				s_axi_arready <= 1'b0;
			end else if (s_axi_rvalid & s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	// Writable fields; read-only and reserved bits are masked off on write
	always @(posedge clk_i) begin
		if (rst_i) begin
			port_opt <= `BOT_PORT_OPT_RST; // R5 R6 R7 R8
			retry_lim <= `BOT_RETRY_LIM_RST; // R9
			pri_tmo <= `BOT_PRI_TMO_RST; // R10
			sec_tmo <= `BOT_SEC_TMO_RST; // R11
			slot_info <= `BOT_SLOT_INFO_RST; // R14
			chassis <= `BOT_CHASSIS_RST; // R14
		end else if (ce_i) begin
			if (wr_opt) begin
				port_opt <= ((port_opt & ~bmask[15:0]) | (w_data[15:0] & bmask[15:0]))
					& `BOT_PORT_OPT_WMASK; // R8
			end
			if (wr_retry) begin
				retry_lim <= (retry_lim & ~bmask) | (w_data & bmask); // R9
			end
			if (wr_tmo) begin
				pri_tmo <= (pri_tmo & ~bmask[15:0]) | (w_data[15:0] & bmask[15:0]); // R10
				sec_tmo <= (sec_tmo & ~bmask[31:16]) | (w_data[31:16] & bmask[31:16]); // R11
			end
			if (wr_slot & w_strb[2]) begin
				slot_info <= w_data[23:16] & `BOT_SLOT_INFO_WMASK; // R14 R8
			end
			if (wr_slot & w_strb[3]) begin
				chassis <= w_data[31:24]; // R14
			end
		end
	end

	// Sticky timeout flags, write one to clear; a new event beats the clear
	always @(posedge clk_i) begin
		if (rst_i) begin
			ev_stat <= 3'h0;
		end else if (ce_i) begin
			if (wr_stat & w_strb[0]) begin
				ev_stat <= (ev_stat & ~w_data[2:0]) | ev_set; // R17
			end else begin
				ev_stat <= ev_stat | ev_set; // R17
			end
		end
	end

	// Policy bits drive the bus masters through one register stage
	always @(posedge clk_i) begin
		if (rst_i) begin
			lock_long_req_o <= 1'b0;
			prim_hold_req_o <= 1'b1;
			sec_hold_req_o <= 1'b1;
		end else if (ce_i) begin
			lock_long_req_o <= port_opt[`BOT_OPT_LOCK_LONG]; // R5
			sec_hold_req_o <= port_opt[`BOT_OPT_SEC_HOLD]; // R6
			prim_hold_req_o <= port_opt[`BOT_OPT_PRI_HOLD]; // R7
		end
	end

	// Primary to secondary forwarding, one cycle of latency
	always @(posedge clk_i) begin
		if (rst_i) begin
			prim_fwd_cmd_o <= 4'h0;
			prim_fwd_valid_o <= 1'b0;
			prim_wi_disconnect_o <= 1'b0;
		end else if (ce_i) begin
			prim_fwd_valid_o <= prim_cmd_valid_i;
			prim_wi_disconnect_o <= 1'b0;
			prim_fwd_cmd_o <= prim_cmd_i;
			if (prim_cmd_valid_i && (prim_cmd_i == `BOT_CMD_WRITE_INVALIDATE)) begin
				if (port_opt[`BOT_OPT_PRI_WI_DISC]) begin
					prim_wi_disconnect_o <= prim_line_end_i; // R4
				end else begin
					prim_fwd_cmd_o <= `BOT_CMD_PLAIN_WRITE; // R2
				end
			end
		end
	end

	// Secondary to primary forwarding, mirror of the above
	always @(posedge clk_i) begin
		if (rst_i) begin
			sec_fwd_cmd_o <= 4'h0;
			sec_fwd_valid_o <= 1'b0;
			sec_wi_disconnect_o <= 1'b0;
		end else if (ce_i) begin
			sec_fwd_valid_o <= sec_cmd_valid_i;
			sec_wi_disconnect_o <= 1'b0;
			sec_fwd_cmd_o <= sec_cmd_i;
			if (sec_cmd_valid_i && (sec_cmd_i == `BOT_CMD_WRITE_INVALIDATE)) begin
				if (port_opt[`BOT_OPT_SEC_WI_DISC]) begin
					sec_wi_disconnect_o <= sec_line_end_i; // R4
				end else begin
					sec_fwd_cmd_o <= `BOT_CMD_PLAIN_WRITE; // R3
				end
			end
		end
	end

	// Retry match: with aliasing, an invalidate-write retry matches a queued write
	always @(posedge clk_i) begin
		if (rst_i) begin
			sec_retry_match_o <= 1'b0;
		end else if (ce_i) begin
			if (!sec_retry_valid_i) begin
				sec_retry_match_o <= 1'b0;
			end else if (sec_retry_cmd_i == sec_queued_cmd_i) begin
				sec_retry_match_o <= 1'b1; // R1
			end else begin
				sec_retry_match_o <= port_opt[`BOT_OPT_SEC_WR_ALIAS] &&
					(sec_retry_cmd_i == `BOT_CMD_WRITE_INVALIDATE) &&
					(sec_queued_cmd_i == `BOT_CMD_PLAIN_WRITE); // R1
			end
		end
	end

	// Attempts against the retry limit; a delivery restarts the count
	bot_limit_counter #(.W(32)) u_retry_cnt (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.clear_i(delivered_i),
		.step_i(attempt_i), // R17
		.limit_i(retry_lim),
		.hit_o(retry_timeout_o)
	);

	// Clocks spent waiting, against each master timeout
	bot_limit_counter #(.W(16)) u_pri_tmo_cnt (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.clear_i(~prim_wait_i),
		.step_i(prim_wait_i), // R17
		.limit_i(pri_tmo),
		.hit_o(prim_timeout_o)
	);

	bot_limit_counter #(.W(16)) u_sec_tmo_cnt (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ce_i(ce_i),
		.clear_i(~sec_wait_i),
		.step_i(sec_wait_i), // R17
		.limit_i(sec_tmo),
		.hit_o(sec_timeout_o)
	);
endmodule // bot_option_regs

`default_nettype wire

// ### tb/bot_regs_props.sv
`default_nettype none
// Port relations of the option block: forwarding, retry matching, policies, timeouts
module bot_regs_props (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [3:0] prim_cmd_i,
	input wire logic prim_cmd_valid_i,
	input wire logic prim_line_end_i,
	input wire logic [3:0] prim_fwd_cmd_o,
	input wire logic prim_fwd_valid_o,
	input wire logic prim_wi_disconnect_o,
	input wire logic [3:0] sec_cmd_i,
	input wire logic sec_cmd_valid_i,
	input wire logic [3:0] sec_fwd_cmd_o,
	input wire logic sec_fwd_valid_o,
	input wire logic [3:0] sec_retry_cmd_i,
	input wire logic [3:0] sec_queued_cmd_i,
	input wire logic sec_retry_valid_i,
	input wire logic sec_retry_match_o,
	input wire logic lock_long_req_o,
	input wire logic prim_hold_req_o,
	input wire logic sec_hold_req_o,
	input wire logic attempt_i,
	input wire logic prim_wait_i,
	input wire logic retry_timeout_o,
	input wire logic prim_timeout_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// A forwarded command is the one taken, or a plain write standing in for an invalidate-write
	a_prim_fwd_cmd: assert property (prim_cmd_valid_i |=> prim_fwd_valid_o &&
		(prim_fwd_cmd_o == $past(prim_cmd_i) || $past(prim_cmd_i) == 4'hF && prim_fwd_cmd_o == 4'h7))
		else $error("primary forward wrong");
	a_sec_fwd_cmd: assert property (sec_cmd_valid_i |=> sec_fwd_valid_o &&
		(sec_fwd_cmd_o == $past(sec_cmd_i) || $past(sec_cmd_i) == 4'hF && sec_fwd_cmd_o == 4'h7))
		else $error("secondary forward wrong");
	// A disconnect only follows an invalidate-write at a line end, which is then not converted
	a_prim_disc_cause: assert property (prim_wi_disconnect_o |-> prim_fwd_cmd_o == 4'hF &&
		$past(prim_cmd_valid_i && prim_line_end_i && prim_cmd_i == 4'hF)) else $error("bad disconnect");
	a_match_exact: assert property (sec_retry_valid_i && sec_retry_cmd_i == sec_queued_cmd_i
		|=> sec_retry_match_o) else $error("exact retry not matched");
	a_match_miss: assert property (sec_retry_valid_i && sec_retry_cmd_i != sec_queued_cmd_i &&
		!(sec_retry_cmd_i == 4'hF && sec_queued_cmd_i == 4'h7) |=> !sec_retry_match_o)
		else $error("foreign retry matched");
	a_policy_reset: assert property ($fell(rst_i) |->
		!lock_long_req_o && prim_hold_req_o && sec_hold_req_o) else $error("policy reset wrong");
	// Timeouts never fire without a step on the cycle before
	a_retry_cause: assert property (retry_timeout_o |-> $past(attempt_i))
		else $error("retry timeout without attempt");
	a_prim_tmo_cause: assert property (prim_timeout_o |-> $past(prim_wait_i))
		else $error("primary timeout without wait");
	c_disc: cover property (prim_wi_disconnect_o);
	c_alias: cover property (sec_retry_match_o && $past(sec_retry_cmd_i) == 4'hF);
	c_retry: cover property (retry_timeout_o);
endmodule // bot_regs_props
bind bot_option_regs bot_regs_props u_props (
	.clk_i, .rst_i, .prim_cmd_i, .prim_cmd_valid_i, .prim_line_end_i, .prim_fwd_cmd_o,
	.prim_fwd_valid_o, .prim_wi_disconnect_o, .sec_cmd_i, .sec_cmd_valid_i, .sec_fwd_cmd_o,
	.sec_fwd_valid_o, .sec_retry_cmd_i, .sec_queued_cmd_i, .sec_retry_valid_i,
	.sec_retry_match_o, .lock_long_req_o, .prim_hold_req_o, .sec_hold_req_o, .attempt_i,
	.prim_wait_i, .retry_timeout_o, .prim_timeout_o
);
`default_nettype wire

// ### tb/bot_host.sv
`default_nettype none
// Configuration host: one write and one read at most, each held until taken
module bot_host (
	input wire logic clk_i,
	output logic [7:0] awaddr_o,
	output logic awvalid_o,
	input wire logic awready_i,
	output logic [31:0] wdata_o,
	output logic [3:0] wstrb_o,
	output logic wvalid_o,
	input wire logic wready_i,
	input wire logic [1:0] bresp_i,
	input wire logic bvalid_i,
	output logic bready_o,
	output logic [7:0] araddr_o,
	output logic arvalid_o,
	input wire logic arready_i,
	input wire logic [31:0] rdata_i,
	input wire logic [1:0] rresp_i,
	input wire logic rvalid_i,
	output logic rready_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// Bus quiet until the first request; whole words only
	initial begin
		{awaddr_o, awvalid_o, wdata_o, wvalid_o, bready_o, araddr_o, arvalid_o, rready_o} = '0;
		wstrb_o = 4'hF;
	end
	// Address and data offered together, each released at its own take
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge clk_i);
		awaddr_o <= a;
		wdata_o <= d;
		{awvalid_o, wvalid_o, bready_o} <= 3'h7;
		fork
			begin
				do @(posedge clk_i); while (!awready_i);
				awvalid_o <= 1'b0;
			end
			begin
				do @(posedge clk_i); while (!wready_i);
				wvalid_o <= 1'b0;
			end
		join
		do @(posedge clk_i); while (!bvalid_i);
		r = bresp_i;
		bready_o <= 1'b0;
	endtask
	// Read waits for the answer however slow; only the bench watchdog ends a hang
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk_i);
		araddr_o <= a;
		{arvalid_o, rready_o} <= 2'h3;
		do @(posedge clk_i); while (!arready_i);
		arvalid_o <= 1'b0;
		do @(posedge clk_i); while (!rvalid_i);
		d = rdata_i;
		r = rresp_i;
		rready_o <= 1'b0;
	endtask
endmodule // bot_host
`default_nettype wire

// ### tb/bot_option_regs_tb.sv
`default_nettype none
module bot_option_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e; logic [1:0] p;} bot_row_t;
	logic clk_i, rst_i, mode0, mode1, prim_cmd_valid_i, prim_line_end_i, sec_cmd_valid_i;
	logic sec_line_end_i, sec_retry_valid_i, attempt_i, prim_wait_i, sec_wait_i, delivered_i;
	logic [3:0] prim_cmd_i, sec_cmd_i, sec_retry_cmd_i, sec_queued_cmd_i;
	logic [3:0] prim_fwd_cmd_o, sec_fwd_cmd_o, s_axi_wstrb;
	logic prim_fwd_valid_o, prim_wi_disconnect_o, sec_fwd_valid_o, sec_wi_disconnect_o;
	logic sec_retry_match_o, lock_long_req_o, prim_hold_req_o, sec_hold_req_o;
	logic retry_timeout_o, prim_timeout_o, sec_timeout_o, s_axi_awvalid, s_axi_awready;
	logic s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
	logic s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd_data;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	int n_mismatch = 0;
	int tests_run = 0;
	// Register rows: write?, address, data, read-back, response
	bot_row_t rows [10] = '{
		'{1'h0, 8'h74, 32'h0, 32'h00000C00, 2'h0},
		'{1'h0, 8'h78, 32'h0, 32'h01000000, 2'h0},
		'{1'h0, 8'h80, 32'h0, 32'h80008000, 2'h0},
		'{1'h0, 8'hB0, 32'h0, 32'h00000004, 2'h0},
		'{1'h1, 8'hDC, 32'hFFFFFFFF, 32'h00010B01, 2'h0},
		'{1'h1, 8'h74, 32'hFFFFFFFF, 32'h00000F90, 2'h0},
		'{1'h1, 8'hB0, 32'hFFFFFFFF, 32'hFF3F0004, 2'h0},
		'{1'h1, 8'h80, 32'h00030002, 32'h00030002, 2'h0},
		'{1'h1, 8'h78, 32'h00000003, 32'h00000003, 2'h0},
		'{1'h1, 8'h10, 32'hFFFFFFFF, 32'h00000000, 2'h2}
	};
	bot_option_regs dut (
		.clk_i, .rst_i, .ce_i(1'b1), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mode_select_pin_zero_i(mode0),
		.mode_select_pin_one_i(mode1), .prim_cmd_i, .prim_cmd_valid_i, .prim_line_end_i,
		.prim_fwd_cmd_o, .prim_fwd_valid_o, .prim_wi_disconnect_o, .sec_cmd_i, .sec_cmd_valid_i,
		.sec_line_end_i, .sec_fwd_cmd_o, .sec_fwd_valid_o, .sec_wi_disconnect_o,
		.sec_retry_cmd_i, .sec_queued_cmd_i, .sec_retry_valid_i, .sec_retry_match_o,
		.lock_long_req_o, .prim_hold_req_o, .sec_hold_req_o, .attempt_i, .delivered_i,
		.prim_wait_i, .sec_wait_i, .retry_timeout_o, .prim_timeout_o, .sec_timeout_o
	);
	bot_host host (
		.clk_i, .awaddr_o(s_axi_awaddr), .awvalid_o(s_axi_awvalid), .awready_i(s_axi_awready),
		.wdata_o(s_axi_wdata), .wstrb_o(s_axi_wstrb), .wvalid_o(s_axi_wvalid),
		.wready_i(s_axi_wready), .bresp_i(s_axi_bresp), .bvalid_i(s_axi_bvalid),
		.bready_o(s_axi_bready), .araddr_o(s_axi_araddr), .arvalid_o(s_axi_arvalid),
		.arready_i(s_axi_arready), .rdata_i(s_axi_rdata), .rresp_i(s_axi_rresp),
		.rvalid_i(s_axi_rvalid), .rready_o(s_axi_rready)
	);
	// 125 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		host.rd(a, rd_data, resp);
		chk(rd_data, e);
	endtask
	// One command on both ports plus a retry compare; outputs looked at in their one cycle
	task automatic cmd(input logic [3:0] c, input logic [3:0] q, input logic [3:0] ef,
			input logic ed, input logic em);
		@(posedge clk_i);
		{prim_cmd_i, sec_cmd_i, sec_retry_cmd_i, sec_queued_cmd_i} <= {c, c, c, q};
		{prim_cmd_valid_i, sec_cmd_valid_i, sec_retry_valid_i} <= 3'h7;
		@(posedge clk_i);
		{prim_cmd_valid_i, sec_cmd_valid_i, sec_retry_valid_i} <= 3'h0;
		#1;
		chk({prim_fwd_cmd_o, sec_fwd_cmd_o, prim_fwd_valid_o, sec_fwd_valid_o}, {ef, ef, 2'h3});
		chk({prim_wi_disconnect_o, sec_wi_disconnect_o}, {ed, ed});
		chk(sec_retry_match_o, em);
	endtask
	task automatic end_sim;
		$display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Watchdog: the sequence needs well under a thousand cycles
	initial begin
		#20000;
		n_mismatch++;
		end_sim;
	end
	// Main sequence
	initial begin
		rst_i = 1'b1;
		mode0 = 1'b1;
		{mode1, prim_cmd_valid_i, sec_cmd_valid_i, sec_retry_valid_i, attempt_i, delivered_i} = '0;
		{prim_wait_i, sec_wait_i, prim_cmd_i, sec_cmd_i, sec_retry_cmd_i, sec_queued_cmd_i} = '0;
		{prim_line_end_i, sec_line_end_i} = 2'h3;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		foreach (rows[i]) begin
			if (rows[i].w) begin
				host.wr(rows[i].a, rows[i].d, resp);
				chk(resp, rows[i].p);
			end
			rdchk(rows[i].a, rows[i].e);
			chk(resp, rows[i].p);
		end
		$display("Test done: register table");
		chk({lock_long_req_o, prim_hold_req_o, sec_hold_req_o}, 3'h7);
		cmd(4'hF, 4'h7, 4'hF, 1'b1, 1'b1);
		cmd(4'h3, 4'h7, 4'h3, 1'b0, 1'b0);
		// Mid-line invalidate-write is neither cut nor converted
		@(posedge clk_i) {prim_line_end_i, sec_line_end_i} <= 2'h0;
		cmd(4'hF, 4'h7, 4'hF, 1'b0, 1'b1);
		@(posedge clk_i) {prim_line_end_i, sec_line_end_i} <= 2'h3;
		host.wr(8'h74, 32'h0, resp);
		cmd(4'hF, 4'h7, 4'h7, 1'b0, 1'b0);
		cmd(4'hF, 4'hF, 4'h7, 1'b0, 1'b1);
		chk({lock_long_req_o, prim_hold_req_o, sec_hold_req_o}, 3'h0);
		$display("Test done: command paths");
		// Strap change needs the synchroniser to settle
		@(posedge clk_i) {mode0, mode1} <= 2'h1;
		repeat (4) @(posedge clk_i);
		rdchk(8'hB0, 32'hFF3F0004);
		mode1 <= 1'b0;
		repeat (4) @(posedge clk_i);
		rdchk(8'hB0, 32'hFF3FDC04);
		mode0 <= 1'b1;
		$display("Test done: strap pointer");
		// Retry limit 3: a delivery throws away two earlier attempts
		repeat (2) begin
			@(posedge clk_i) attempt_i <= 1'b1;
			@(posedge clk_i) attempt_i <= 1'b0;
		end
		@(posedge clk_i) delivered_i <= 1'b1;
		@(posedge clk_i) delivered_i <= 1'b0;
		// Two attempts stay quiet, the third fires
		for (int k = 0; k < 3; k++) begin
			rdchk(8'hF0, 32'h0);
			@(posedge clk_i) attempt_i <= 1'b1;
			@(posedge clk_i) attempt_i <= 1'b0;
			#1 chk(retry_timeout_o, k == 2);
		end
		// Limits 2 and 3: primary pulses after 2 and 4 waits, secondary after 3
		@(posedge clk_i) {prim_wait_i, sec_wait_i} <= 2'h3;
		repeat (3) @(posedge clk_i);
		#1 chk({prim_timeout_o, sec_timeout_o}, 2'h1);
		@(posedge clk_i) {prim_wait_i, sec_wait_i} <= 2'h0;
		#1 chk({prim_timeout_o, sec_timeout_o}, 2'h2);
		rdchk(8'hF0, 32'h7);
		// Writing ones clears the sticky flags
		host.wr(8'hF0, 32'h00000007, resp);
		rdchk(8'hF0, 32'h0);
		$display("Test done: timeouts");
		// Reset in mid-run restores every default
		@(posedge clk_i) rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		rdchk(8'h74, 32'h00000C00);
		rdchk(8'hB0, 32'h00000004);
		chk({lock_long_req_o, prim_hold_req_o, sec_hold_req_o}, 3'h3);
		$display("Test done: second reset");
		end_sim;
	end
endmodule // bot_option_regs_tb
`default_nettype wire
